// file: src/cnt_out_cfg.svh
// Timing figures and reset values for the counter output block
`ifndef CNT_OUT_CFG_SVH
`define CNT_OUT_CFG_SVH

`define COS_CLK_PERIOD_NS 20
`define COS_VALID_TIME_NS 160
`define COS_PULSE_TIME_NS 80
`define COS_PIN_IDLE 1'b1
`define COS_FILT_LEVEL_RST 1'b1
`define COS_COUNT_WIDTH 24

`endif

// file: src/cnt_out_pkg.sv
// Types shared by the counter output block
package cnt_out_pkg;

    typedef enum logic [1:0] {
        OUT_PULSE_LOW,
        OUT_TOGGLE,
        OUT_PULSE_HIGH,
        OUT_COMPARE
    } out_pair_e;

    typedef enum logic [1:0] {
        QUAD_OFF,
        QUAD_X1,
        QUAD_X2,
        QUAD_X4
    } quad_mode_e;

endpackage

// file: src/quad_filter_if.sv
// Raw and filtered count inputs between the top and the input filter
`timescale 1ns/10ps
`default_nettype none

interface quad_filter_if;
    logic [1:0] raw;
    logic [1:0] filt;

    modport src
    (
        output raw,
        input filt
    );

    modport flt
    (
        input raw,
        output filt
    );
endinterface

`default_nettype wire

// file: src/quad_filter.sv
// Stability filter for the two quadrature count inputs
`include "cnt_out_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module quad_filter #(
    parameter int VALID_CYC = 8
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Inputs and filtered levels
    quad_filter_if.flt qf
);
    localparam int CW = $clog2(VALID_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(VALID_CYC - 1);

    typedef struct packed {
        logic [1:0] level;
        logic [1:0][CW-1:0] cnt;
    } filt_s;

    filt_s s_reg;
    filt_s s_next;

    always_comb
    begin
        s_next = s_reg;
        for (int i = 0; i < 2; i++)
        begin
            if (qf.raw[i] == s_reg.level[i])
            begin
                s_next.cnt[i] = '0;
            end
            else if (s_reg.cnt[i] == LAST)
            begin
                s_next.level[i] = qf.raw[i];
                s_next.cnt[i] = '0;
            end
            else
            begin
                s_next.cnt[i] = s_reg.cnt[i] + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_reg.level <= {2{`COS_FILT_LEVEL_RST}};
            s_reg.cnt <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign qf.filt = s_reg.level;
endmodule

`default_nettype wire

// file: src/counter_output_select_qualify.sv
// Up/down counter with selectable carry, borrow and compare output pins
`include "cnt_out_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module counter_output_select_qualify #(
    parameter int WIDTH = `COS_COUNT_WIDTH
)
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Count inputs
    input wire logic in_a_i,
    input wire logic in_b_i,
    // Mode settings
    input wire logic [1:0] output_control_setting_i,
    input wire logic [1:0] quad_mode_i,
    input wire logic dir_input_mode_i,
    input wire logic count_enable_i,
    input wire logic non_recycle_i,
    input wire logic divide_n_i,
    // Commands
    input wire logic master_reset_i,
    input wire logic counter_reset_i,
    input wire logic compare_toggle_clear_i,
    input wire logic counter_load_input_n_i,
    input wire logic [WIDTH-1:0] preset_value_i,
    // Output pins
    output logic carry_out_o,
    output logic borrow_out_o,
    // Status
    output logic carry_toggle_level_o,
    output logic borrow_toggle_level_o,
    output logic compare_toggle_level_o,
    output logic count_up_o,
    output logic [WIDTH-1:0] main_counter_o
);
    // Longest validation time rounds down, pulse width rounds up
    localparam int VALID_CYC = `COS_VALID_TIME_NS / `COS_CLK_PERIOD_NS;
    localparam int PULSE_CYC = (`COS_PULSE_TIME_NS + `COS_CLK_PERIOD_NS - 1)
                               / `COS_CLK_PERIOD_NS;
    localparam int SW = $clog2(PULSE_CYC + 1);
    localparam logic [SW-1:0] PULSE_LOAD = SW'(PULSE_CYC);

    typedef struct packed {
        logic a_prev;
        logic b_prev;
        logic [WIDTH-1:0] cnt;
        logic run;
        logic cmp_armed;
        logic up;
        logic carry_toggle_level;
        logic borrow_toggle_level;
        logic compare_toggle_level;
        logic [SW-1:0] cy_str;
        logic [SW-1:0] bw_str;
        logic [SW-1:0] cmp_str;
        logic pin_cy;
        logic pin_bw;
    } state_s;

    state_s s_reg;
    state_s s_next;
    logic [1:0] rst_sync_reg;
    logic rst_n;
    cnt_out_pkg::out_pair_e sel;
    cnt_out_pkg::quad_mode_e qmode;
    logic a_in;
    logic b_in;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic a_edge;
    logic b_edge;
    logic inc;
    logic dec;
    logic evt;
    logic carry;
    logic borrow;
    logic cmp_hit;

    quad_filter_if qf();

    // Pulse stretcher: reload on an event, else run down to zero
    function automatic logic [SW-1:0] stretch(input logic [SW-1:0] cur, input logic fire);
        logic [SW-1:0] res;
        res = cur;
        if (fire)
        begin
            res = PULSE_LOAD;
        end
        else if (cur != '0)
        begin
            res = cur - SW'(1);
        end
        return res;
    endfunction

    // Reset released through two flops, asserted at once
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];
    assign qf.raw = {in_b_i, in_a_i};
    assign sel = cnt_out_pkg::out_pair_e'(output_control_setting_i);
    assign qmode = cnt_out_pkg::quad_mode_e'(quad_mode_i);

    quad_filter #(
        .VALID_CYC(VALID_CYC)
    ) u_filter (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .qf(qf.flt)
    );

    always_comb
    begin
        s_next = s_reg;
        a_in = (qmode == cnt_out_pkg::QUAD_OFF) ? in_a_i : qf.filt[0];
        b_in = (qmode == cnt_out_pkg::QUAD_OFF) ? in_b_i : qf.filt[1];
        a_rise = a_in & ~s_reg.a_prev;
        a_fall = ~a_in & s_reg.a_prev;
        b_rise = b_in & ~s_reg.b_prev;
        a_edge = a_in ^ s_reg.a_prev;
        b_edge = b_in ^ s_reg.b_prev;
        s_next.a_prev = a_in;
        s_next.b_prev = b_in;
        inc = 1'b0;
        dec = 1'b0;
        case (qmode)
            cnt_out_pkg::QUAD_OFF:
            begin
                if (dir_input_mode_i)
                begin
                    inc = a_rise & ~b_in;
                    dec = a_rise & b_in;
                end
                else
                begin
                    // idle input is held high by source
                    inc = a_rise;
                    dec = b_rise;
                end
            end
            cnt_out_pkg::QUAD_X1:
            begin
                inc = a_rise & ~b_in;
                dec = a_fall & ~b_in;
            end
            cnt_out_pkg::QUAD_X2:
            begin
                inc = a_edge & (a_in != b_in);
                dec = a_edge & (a_in == b_in);
            end
            cnt_out_pkg::QUAD_X4:
            begin
                inc = (a_edge & (a_in != b_in)) | (b_edge & (a_in == b_in));
                dec = (a_edge & (a_in == b_in)) | (b_edge & (a_in != b_in));
            end
            default:
            begin
                inc = 1'b0;
                dec = 1'b0;
            end
        endcase
        // Opposing counts in one cycle cancel
        evt = (inc ^ dec) & count_enable_i & s_reg.run;
        carry = evt & inc & (s_reg.cnt == {WIDTH{1'b1}});
        borrow = evt & dec & (s_reg.cnt == '0);
        // match only counts once a count edge has rearmed it
        cmp_hit = s_reg.cmp_armed & (s_reg.cnt == preset_value_i);
        s_next.cmp_armed = 1'b0;

        if (evt)
        begin
            s_next.up = inc;
            s_next.cnt = inc ? s_reg.cnt + WIDTH'(1) : s_reg.cnt - WIDTH'(1);
            s_next.cmp_armed = 1'b1;
            // Reload in divide-by-N; rate limit is the source's job
            if ((carry | borrow) & divide_n_i)
            begin
                s_next.cnt = preset_value_i;
            end
            if ((carry | borrow) & non_recycle_i)
            begin
                s_next.run = 1'b0;
            end
        end
        s_next.carry_toggle_level = s_reg.carry_toggle_level ^ carry;
        s_next.borrow_toggle_level = s_reg.borrow_toggle_level ^ borrow;
        // A hit in the clear cycle still flips the level
        s_next.compare_toggle_level = (compare_toggle_clear_i ? 1'b0 : s_reg.compare_toggle_level) ^ cmp_hit;

        // no external carry or borrow pulse in non-recycle
        s_next.cy_str = stretch(s_reg.cy_str, carry & ~non_recycle_i);
        s_next.bw_str = stretch(s_reg.bw_str, borrow & ~non_recycle_i);
        s_next.cmp_str = stretch(s_reg.cmp_str, cmp_hit);

        if (master_reset_i | counter_reset_i)
        begin
            s_next.cnt = '0;
            s_next.carry_toggle_level = 1'b0;
            s_next.borrow_toggle_level = 1'b0;
            s_next.run = 1'b1;
            s_next.cmp_armed = 1'b0;
        end
        else if (!counter_load_input_n_i)
        begin
            s_next.cnt = preset_value_i;
            s_next.run = 1'b1;
            s_next.cmp_armed = 1'b0;
        end
        if (master_reset_i)
        begin
            s_next.compare_toggle_level = 1'b0;
            s_next.up = 1'b1;
            s_next.cy_str = '0;
            s_next.bw_str = '0;
            s_next.cmp_str = '0;
        end

        case (sel)
            cnt_out_pkg::OUT_PULSE_LOW:
            begin
                s_next.pin_cy = s_next.cy_str == '0;
                s_next.pin_bw = s_next.bw_str == '0;
            end
            cnt_out_pkg::OUT_TOGGLE:
            begin
                s_next.pin_cy = s_next.carry_toggle_level;
                s_next.pin_bw = s_next.borrow_toggle_level;
            end
            cnt_out_pkg::OUT_PULSE_HIGH:
            begin
                s_next.pin_cy = s_next.cy_str != '0;
                s_next.pin_bw = s_next.bw_str != '0;
            end
            cnt_out_pkg::OUT_COMPARE:
            begin
                s_next.pin_cy = s_next.cmp_str == '0;
                s_next.pin_bw = s_next.compare_toggle_level;
            end
            default:
            begin
                s_next.pin_cy = `COS_PIN_IDLE;
                s_next.pin_bw = `COS_PIN_IDLE;
            end
        endcase
    end

    // Prev levels reset high to match idle inputs
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.a_prev <= `COS_FILT_LEVEL_RST;
            s_reg.b_prev <= `COS_FILT_LEVEL_RST;
            s_reg.run <= 1'b1;
            s_reg.up <= 1'b1;
            s_reg.pin_cy <= `COS_PIN_IDLE;
            s_reg.pin_bw <= `COS_PIN_IDLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign carry_out_o = s_reg.pin_cy;
    assign borrow_out_o = s_reg.pin_bw;
    assign carry_toggle_level_o = s_reg.carry_toggle_level;
    assign borrow_toggle_level_o = s_reg.borrow_toggle_level;
    assign compare_toggle_level_o = s_reg.compare_toggle_level;
    assign count_up_o = s_reg.up;
    assign main_counter_o = s_reg.cnt;
endmodule

`default_nettype wire

// file: sim/cnt_src_model.sv
// Count pulse source on the two count inputs
`timescale 1ns/10ps
`default_nettype none
module cnt_src_model
(
    // Clock
    input wire logic clk_i,
    // Count lines
    output logic a_o,
    output logic b_o
);
    initial
    begin
        a_o = 1'h1;
        b_o = 1'h1;
    end

    task automatic drive(input logic a, input logic b, input int n);
        @(posedge clk_i);
        #1;
        a_o = a;
        b_o = b;
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic step(input logic up);
        drive(!up, up, 3);
        drive(1'h1, 1'h1, 12);
    endtask
endmodule
`default_nettype wire

// file: sim/cos_check_assertions.sv
// Port assertions for the counter output block
`timescale 1ns/10ps
`default_nettype none
module cos_check #(parameter int WIDTH = 24)
(
    // Clock, reset and inputs
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic in_a_i,
    input wire logic [1:0] output_control_setting_i,
    input wire logic [1:0] quad_mode_i,
    input wire logic master_reset_i,
    input wire logic counter_reset_i,
    input wire logic compare_toggle_clear_i,
    input wire logic counter_load_input_n_i,
    input wire logic non_recycle_i,
    // Outputs
    input wire logic carry_out_o,
    input wire logic borrow_out_o,
    input wire logic carry_toggle_level_o,
    input wire logic borrow_toggle_level_o,
    input wire logic compare_toggle_level_o,
    input wire logic [WIDTH-1:0] main_counter_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic [1:0] sel = output_control_setting_i;

    carry_toggle_a:
    assert property ((sel == 2'h1)[*2] |-> carry_out_o == carry_toggle_level_o)
        else $error("carry pin not toggle level");
    borrow_toggle_a:
    assert property ((sel == 2'h1)[*2] |-> borrow_out_o == borrow_toggle_level_o)
        else $error("borrow pin not toggle level");
    compare_toggle_a:
    assert property ((sel == 2'h3)[*2] |-> borrow_out_o == compare_toggle_level_o)
        else $error("borrow pin not compare level");
    compare_pulse_a:
    assert property (sel == 2'h3 && $stable(sel) && $changed(compare_toggle_level_o)
        && !$past(compare_toggle_clear_i) && !$past(master_reset_i) |-> !carry_out_o)
        else $error("no compare pulse");
    low_width_a:
    assert property (sel == 2'h0 && $stable(sel) && $fell(carry_out_o)
        |-> !carry_out_o[*4] ##1 carry_out_o) else $error("low pulse width");
    high_width_a:
    assert property (sel == 2'h2 && $stable(sel) && $rose(borrow_out_o)
        |-> borrow_out_o[*4] ##1 !borrow_out_o) else $error("high pulse width");
    recycle_quiet_a:
    assert property ((non_recycle_i && sel == 2'h0)[*6] |-> carry_out_o && borrow_out_o)
        else $error("pulse in non-recycle mode");
    load_block_a:
    assert property ((!counter_load_input_n_i && !compare_toggle_clear_i
        && !master_reset_i)[*2] |=> $stable(compare_toggle_level_o))
        else $error("compare during load");
    quad_filter_a:
    assert property (quad_mode_i != 2'h0 && $changed(in_a_i) && counter_load_input_n_i
        && !counter_reset_i && !master_reset_i |-> $stable(main_counter_o)[*7])
        else $error("unfiltered quad input");
endmodule
bind counter_output_select_qualify cos_check #(.WIDTH(WIDTH)) chk (.sys_clk_i, .rstn_i,
    .in_a_i, .output_control_setting_i, .quad_mode_i, .master_reset_i, .counter_reset_i,
    .compare_toggle_clear_i, .counter_load_input_n_i, .non_recycle_i, .carry_out_o,
    .borrow_out_o, .carry_toggle_level_o, .borrow_toggle_level_o, .compare_toggle_level_o,
    .main_counter_o);
`default_nettype wire

// file: sim/tb.sv
// Directed testbench for the counter output block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk_i;
    logic rstn_i;
    wire logic in_a;
    wire logic in_b;
    logic [1:0] sel;
    logic [1:0] quad;
    logic non_recycle;
    logic master_reset;
    logic cmp_clear;
    logic load_n;
    logic [23:0] preset;
    logic cy_pin;
    logic bw_pin;
    logic carry_toggle_level;
    logic borrow_toggle_level;
    logic compare_toggle_level;
    logic [23:0] cnt;
    logic up;
    int err_total;
    int comparisons;
    int cy1;
    int bw1;

    cnt_src_model src (.clk_i(sys_clk_i), .a_o(in_a), .b_o(in_b));

    counter_output_select_qualify DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .in_a_i(in_a), .in_b_i(in_b), .output_control_setting_i(sel), .quad_mode_i(quad),
        .dir_input_mode_i(1'h0), .count_enable_i(1'h1), .non_recycle_i(non_recycle),
        .divide_n_i(1'h0), .master_reset_i(master_reset), .counter_reset_i(1'h0),
        .compare_toggle_clear_i(cmp_clear), .counter_load_input_n_i(load_n),
        .preset_value_i(preset), .carry_out_o(cy_pin), .borrow_out_o(bw_pin),
        .carry_toggle_level_o(carry_toggle_level), .borrow_toggle_level_o(borrow_toggle_level),
        .compare_toggle_level_o(compare_toggle_level), .count_up_o(up), .main_counter_o(cnt));

    initial
    begin
        sys_clk_i = 1'h0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    // Pin high time over a window
    always @(negedge sys_clk_i)
    begin
        cy1 += cy_pin;
        bw1 += bw_pin;
    end

    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task chk_v(input logic [23:0] got, input logic [23:0] exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task chk_n(input int got, input int exp, input string m);
        comparisons++;
        if (got != exp)
        begin
            err_total++;
            $display("MISMATCH %0t %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask

    // Window is 17 cycles; a negative borrow figure skips the borrow pin, carry is always checked
    task run(input logic up, input int ecy, input int ebw);
        cy1 = 0;
        bw1 = 0;
        src.step(up);
        chk_n(cy1, ecy, "carry pin");
        if (ebw >= 0)
            chk_n(bw1, ebw, "borrow pin");
    endtask

    task load(input logic [23:0] v);
        preset = v;
        load_n = 1'h0;
        cyc(2);
        load_n = 1'h1;
        cyc(5);
    endtask

    task conclude;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge sys_clk_i);
        err_total++;
        conclude;
    end

    initial
    begin
        rstn_i = 1'h0;
        sel = 2'h0;
        quad = 2'h0;
        non_recycle = 1'h0;
        master_reset = 1'h0;
        cmp_clear = 1'h0;
        load_n = 1'h1;
        preset = 24'h000100;
        err_total = 0;
        comparisons = 0;
        cyc(8);
        rstn_i = 1'h1;
        cyc(3);
        chk_v({cy_pin, bw_pin, carry_toggle_level, borrow_toggle_level, compare_toggle_level}, 24'h000018, "reset pins");
        run(1'h0, 17, 13);
        chk_v(cnt, 24'hFFFFFF, "underflow");
        run(1'h1, 13, 17);
        sel = 2'h2;
        cyc(2);
        run(1'h0, 0, 4);
        run(1'h1, 4, 0);
        sel = 2'h1;
        cyc(2);
        src.step(1'h0);
        chk_v({cy_pin, bw_pin, carry_toggle_level, borrow_toggle_level}, 24'h000005, "toggle pins");
        sel = 2'h3;
        load(24'h000002);
        chk_v(cnt, 24'h000002, "load value");
        chk_v({cy_pin, compare_toggle_level}, 24'h000002, "load no compare");
        run(1'h1, 17, 0);
        run(1'h0, 13, -1);
        chk_v(cnt, 24'h000002, "compare level");
        chk_v({bw_pin, compare_toggle_level}, 24'h000003, "compare pin");
        cmp_clear = 1'h1;
        cyc(1);
        cmp_clear = 1'h0;
        sel = 2'h0;
        non_recycle = 1'h1;
        load(24'h000000);
        run(1'h0, 17, 17);
        chk_v(cnt, 24'hFFFFFF, "cycle complete");
        chk_v({borrow_toggle_level, up}, 24'h000000, "toggle and direction");
        non_recycle = 1'h0;
        load(24'h000000);
        quad = 2'h2;
        cyc(2);
        src.drive(1'h0, 1'h1, 5);
        src.drive(1'h1, 1'h1, 12);
        chk_v(cnt, 24'h000000, "glitch counted");
        src.drive(1'h0, 1'h1, 12);
        chk_v(cnt, 24'h000001, "quad count");
        master_reset = 1'h1;
        cyc(1);
        master_reset = 1'h0;
        cyc(2);
        chk_v(cnt, 24'h000000, "master reset");
        conclude;
    end
endmodule
`default_nettype wire
